// ==== pkg/ccc_pkg.sv ====
// Package of offsets, fields, reset values and types for the clock controller
`default_nettype none
package ccc_pkg;
	// Register byte offsets
	localparam logic [7:0] CCC_OFF_CTRL = 8'h00;
	localparam logic [7:0] CCC_OFF_DIV = 8'h04;
	localparam logic [7:0] CCC_OFF_STATUS = 8'h08;
	localparam logic [7:0] CCC_OFF_IRQ_STAT = 8'h0C;
	localparam logic [7:0] CCC_OFF_IRQ_MASK = 8'h10;
	// Control register bit positions
	localparam int CCC_CTRL_SW_EN = 0;
	localparam int CCC_CTRL_TARGET = 1;
	localparam int CCC_CTRL_MON_EN = 3;
	localparam int CCC_CTRL_PLL_EN = 4;
	localparam int CCC_CTRL_PLL_SRC = 5;
	localparam int CCC_CTRL_DBG_DIV2 = 6;
	localparam int CCC_CTRL_EMERG = 7;
	localparam int CCC_CTRL_OUT_EN = 8;
	// Divider register field positions
	localparam int CCC_DIV_SYS_PRE = 0;
	localparam int CCC_DIV_CPU = 2;
	localparam int CCC_DIV_TRIM = 5;
	localparam int CCC_DIV_PLL = 8;
	localparam int CCC_DIV_PLL_PRE = 10;
	localparam int CCC_DIV_OUT_SEL = 12;
	localparam int CCC_DIV_OUT_N = 16;
	// Status register bit positions
	localparam int CCC_ST_SLOW_RDY = 0;
	localparam int CCC_ST_FAST_RDY = 1;
	localparam int CCC_ST_EXT_RDY = 2;
	localparam int CCC_ST_SW_DONE = 3;
	localparam int CCC_ST_SW_BUSY = 4;
	localparam int CCC_ST_FAIL = 5;
	localparam int CCC_ST_AUX = 6;
	localparam int CCC_ST_OUT_BUSY = 7;
	localparam int CCC_ST_OUT_RDY = 8;
	localparam int CCC_ST_SRC = 9;
	// Interrupt bit positions
	localparam int CCC_IRQ_FAIL = 0;
	localparam int CCC_IRQ_SWITCH = 1;
	// Values after reset
	localparam logic [1:0] CCC_RST_SYS_PRE = 2'h3;
	localparam logic [2:0] CCC_RST_CPU = 3'h0;
	localparam logic [2:0] CCC_RST_TRIM = 3'h0;
	localparam logic [1:0] CCC_RST_PLL = 2'h2;
	localparam logic [1:0] CCC_RST_PLL_PRE = 2'h0;
	localparam logic [3:0] CCC_RST_OUT_SEL = 4'h0;
	localparam logic [7:0] CCC_RST_OUT_N = 8'h00;
	localparam logic CCC_RST_DBG_DIV2 = 1'b1;
	// Divider ratios, stored as ratio minus one
	localparam logic [7:0] CCC_PLL_DIV_BASE = 8'h03;
	localparam logic [7:0] CCC_AUX_RATIO_M1 = 8'h07;
	// Master clock sources
	typedef enum logic [1:0] {
		CCC_SRC_FAST_INT = 2'h0,
		CCC_SRC_SLOW_INT = 2'h1,
		CCC_SRC_FAST_EXT = 2'h2
	} ccc_src_type;
	// Clock switch states
	typedef enum logic {
		CCC_SW_IDLE,
		CCC_SW_WAIT
	} ccc_sw_state_type;
endpackage
`default_nettype wire

// ==== verilog/ccc_tick_div.sv ====
// Programmable divider of a one-cycle tick stream
`default_nettype none
module ccc_tick_div
	import ccc_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic tick_i,
	input wire logic [W-1:0] ratio_m1_i,
	output logic tick_o
);
	logic [W-1:0] cnt;

	// Count input ticks, emit one per ratio; new ratio applies at once
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt <= '0;
			tick_o <= 1'b0;
		end else if (tick_i) begin
			if (cnt >= ratio_m1_i) begin
				cnt <= '0;
				tick_o <= 1'b1;
			end else begin
				cnt <= cnt + 1'b1;
				tick_o <= 1'b0;
			end
		end else begin
			tick_o <= 1'b0;
		end
	end

	// Ratio one passes every tick through
	a_unit_pass: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(tick_i && ratio_m1_i == '0) |=> tick_o)
		else $error("divider by one dropped a tick");
endmodule
`default_nettype wire

// ==== verilog/ccc_clock_ctrl.sv ====
// Clock controller: source switch, prescalers, trim, PLL, clock output, failure monitor
`default_nettype none
module ccc_clock_ctrl
	import ccc_pkg::*;
#(
	parameter int CAL_W = 8
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic fast_int_tick_i,
	input wire logic slow_int_tick_i,
	input wire logic fast_ext_tick_i,
	input wire logic fast_int_ready_i,
	input wire logic slow_int_ready_i,
	input wire logic fast_ext_ready_i,
	input wire logic fast_ext_fail_i,
	input wire logic [5:0] sm_tick_i,
	input wire logic adc_tick_i,
	input wire logic awu_tick_i,
	input wire logic [CAL_W-1:0] factory_cal_i,
	output logic [CAL_W-1:0] fast_int_trim_o,
	output logic master_tick_o,
	output logic cpu_tick_o,
	output logic debug_wire_tick_o,
	output logic pll_tick_o,
	output logic pll_div_tick_o,
	output logic pll_pres_tick_o,
	output logic clock_output_tick_o,
	output logic irq_o
);
	// Control fields
	logic switch_enable_bit;
	ccc_src_type target_src;
	logic monitor_en;
	logic pll_en;
	logic pll_src_ext;
	logic dbg_div2;
	logic out_en;
	logic [1:0] sys_pre;
	logic [2:0] cpu_div;
	logic [2:0] trim;
	logic [1:0] pll_div;
	logic [1:0] pll_pre;
	logic [3:0] out_sel;
	logic [7:0] out_n;
	// State and flags
	ccc_sw_state_type sw_state;
	ccc_src_type cur_src;
	logic switch_busy_flag;
	logic switch_done_flag;
	logic clock_fail_detect_flag;
	logic aux_flag;
	logic clock_output_busy_flag;
	logic clock_output_ready_flag;
	logic [1:0] irq_mask;
	// Bus decode
	logic acc;
	logic wr;
	logic [31:0] wmask;
	logic [31:0] wdat;
	logic wr_ctrl;
	logic wr_div;
	logic wr_istat;
	logic wr_imask;
	logic [31:0] next_readdata;
	// Clock path nets
	logic sys_tick;
	logic aux_tick;
	logic next_master;
	logic target_ready;
	logic fail_event;
	logic emerg_clear;
	logic [15:0] out_srcs;
	logic out_tick_sel;

	// Bus handshake: one wait cycle, then a single accepting cycle
	assign acc = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
	assign wr = acc && avs_write_i;
	assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
		{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	assign wdat = avs_writedata_i & wmask;
	assign wr_ctrl = wr && avs_address_i == CCC_OFF_CTRL;
	assign wr_div = wr && avs_address_i == CCC_OFF_DIV;
	assign wr_istat = wr && avs_address_i == CCC_OFF_IRQ_STAT;
	assign wr_imask = wr && avs_address_i == CCC_OFF_IRQ_MASK;
	assign emerg_clear = wr_ctrl && wdat[CCC_CTRL_EMERG];

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		unique case (avs_address_i)
			CCC_OFF_CTRL: begin
				next_readdata[CCC_CTRL_SW_EN] = switch_enable_bit;
				next_readdata[CCC_CTRL_TARGET +: 2] = target_src;
				next_readdata[CCC_CTRL_MON_EN] = monitor_en;
				next_readdata[CCC_CTRL_PLL_EN] = pll_en;
				next_readdata[CCC_CTRL_PLL_SRC] = pll_src_ext;
				next_readdata[CCC_CTRL_DBG_DIV2] = dbg_div2;
				next_readdata[CCC_CTRL_OUT_EN] = out_en;
			end
			CCC_OFF_DIV: begin
				next_readdata[CCC_DIV_SYS_PRE +: 2] = sys_pre;
				next_readdata[CCC_DIV_CPU +: 3] = cpu_div;
				next_readdata[CCC_DIV_TRIM +: 3] = trim;
				next_readdata[CCC_DIV_PLL +: 2] = pll_div;
				next_readdata[CCC_DIV_PLL_PRE +: 2] = pll_pre;
				next_readdata[CCC_DIV_OUT_SEL +: 4] = out_sel;
				next_readdata[CCC_DIV_OUT_N +: 8] = out_n;
			end
			CCC_OFF_STATUS: begin
				next_readdata[CCC_ST_SLOW_RDY] = slow_int_ready_i;
				next_readdata[CCC_ST_FAST_RDY] = fast_int_ready_i;
				next_readdata[CCC_ST_EXT_RDY] = fast_ext_ready_i;
				next_readdata[CCC_ST_SW_DONE] = switch_done_flag;
				next_readdata[CCC_ST_SW_BUSY] = switch_busy_flag;
				next_readdata[CCC_ST_FAIL] = clock_fail_detect_flag;
				next_readdata[CCC_ST_AUX] = aux_flag;
				next_readdata[CCC_ST_OUT_BUSY] = clock_output_busy_flag;
				next_readdata[CCC_ST_OUT_RDY] = clock_output_ready_flag;
				next_readdata[CCC_ST_SRC +: 2] = cur_src;
			end
			CCC_OFF_IRQ_STAT: begin
				next_readdata[CCC_IRQ_FAIL] = clock_fail_detect_flag;
				next_readdata[CCC_IRQ_SWITCH] = switch_done_flag;
			end
			CCC_OFF_IRQ_MASK: begin
				next_readdata[1:0] = irq_mask;
			end
			default: begin
				next_readdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i && avs_waitrequest_o) begin
			avs_readdata_o <= next_readdata;
		end
	end

	// Control register; monitor enable can only be set
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			target_src <= CCC_SRC_FAST_INT;
			monitor_en <= 1'b0;
			pll_en <= 1'b0;
			pll_src_ext <= 1'b0;
			dbg_div2 <= CCC_RST_DBG_DIV2;
			out_en <= 1'b0;
		end else if (wr_ctrl) begin
			if (avs_byteenable_i[0]) begin
				target_src <= ccc_src_type'(avs_writedata_i[CCC_CTRL_TARGET +: 2]);
				monitor_en <= monitor_en | avs_writedata_i[CCC_CTRL_MON_EN];
				pll_en <= avs_writedata_i[CCC_CTRL_PLL_EN];
				pll_src_ext <= avs_writedata_i[CCC_CTRL_PLL_SRC];
				dbg_div2 <= avs_writedata_i[CCC_CTRL_DBG_DIV2];
			end
			if (avs_byteenable_i[1]) begin
				out_en <= avs_writedata_i[CCC_CTRL_OUT_EN];
			end
		end
	end

	// Divider register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sys_pre <= CCC_RST_SYS_PRE;
			cpu_div <= CCC_RST_CPU;
			trim <= CCC_RST_TRIM;
			pll_div <= CCC_RST_PLL;
			pll_pre <= CCC_RST_PLL_PRE;
			out_sel <= CCC_RST_OUT_SEL;
			out_n <= CCC_RST_OUT_N;
		end else if (wr_div) begin
			if (avs_byteenable_i[0]) begin
				sys_pre <= avs_writedata_i[CCC_DIV_SYS_PRE +: 2];
				cpu_div <= avs_writedata_i[CCC_DIV_CPU +: 3];
				trim <= avs_writedata_i[CCC_DIV_TRIM +: 3];
			end
			if (avs_byteenable_i[1]) begin
				pll_div <= avs_writedata_i[CCC_DIV_PLL +: 2];
				pll_pre <= avs_writedata_i[CCC_DIV_PLL_PRE +: 2];
				out_sel <= avs_writedata_i[CCC_DIV_OUT_SEL +: 4];
			end
			if (avs_byteenable_i[2]) begin
				out_n <= avs_writedata_i[CCC_DIV_OUT_N +: 8];
			end
		end
	end

	// Interrupt mask register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_mask <= 2'h0;
		end else if (wr_imask && avs_byteenable_i[0]) begin
			irq_mask <= avs_writedata_i[1:0];
		end
	end

	// Clock switch sequencer
	always_comb begin
		unique case (target_src)
			CCC_SRC_SLOW_INT: target_ready = slow_int_ready_i;
			CCC_SRC_FAST_EXT: target_ready = fast_ext_ready_i;
			default: target_ready = fast_int_ready_i;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sw_state <= CCC_SW_IDLE;
			switch_enable_bit <= 1'b0;
			switch_busy_flag <= 1'b0;
			cur_src <= CCC_SRC_FAST_INT;
		end else if (emerg_clear) begin
			sw_state <= CCC_SW_IDLE;
			switch_enable_bit <= 1'b0;
			switch_busy_flag <= 1'b0;
		end else begin
			unique case (sw_state)
				CCC_SW_IDLE: begin
					if (wr_ctrl && avs_byteenable_i[0] && avs_writedata_i[CCC_CTRL_SW_EN]) begin
						sw_state <= CCC_SW_WAIT;
						switch_enable_bit <= 1'b1;
						switch_busy_flag <= 1'b1;
					end
				end
				CCC_SW_WAIT: begin
					if (target_ready) begin
						sw_state <= CCC_SW_IDLE;
						switch_enable_bit <= 1'b0;
						switch_busy_flag <= 1'b0;
						cur_src <= target_src;
					end
				end
			endcase
		end
	end

	// Failure detection, aux connection and sticky flags; set beats clear
	assign fail_event = monitor_en && cur_src == CCC_SRC_FAST_EXT && fast_ext_fail_i && !aux_flag;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			clock_fail_detect_flag <= 1'b0;
			aux_flag <= 1'b0;
		end else begin
			if (fail_event) begin
				clock_fail_detect_flag <= 1'b1;
			end else if (wr_istat && wdat[CCC_IRQ_FAIL]) begin
				clock_fail_detect_flag <= 1'b0;
			end
			if (fail_event) begin
				aux_flag <= 1'b1;
			end else if (sw_state == CCC_SW_WAIT && target_ready && !emerg_clear) begin
				aux_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			switch_done_flag <= 1'b0;
		end else if (sw_state == CCC_SW_WAIT && target_ready && !emerg_clear) begin
			switch_done_flag <= 1'b1;
		end else if (wr_istat && wdat[CCC_IRQ_SWITCH]) begin
			switch_done_flag <= 1'b0;
		end
	end

	// Interrupt output from pending bits and mask
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= (irq_mask[CCC_IRQ_FAIL] && clock_fail_detect_flag)
				|| (irq_mask[CCC_IRQ_SWITCH] && switch_done_flag);
		end
	end

	// System prescaler and auxiliary divide by eight
	ccc_tick_div #(.W(8)) u_sys_pre (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(fast_int_tick_i),
		.ratio_m1_i(8'((8'h01 << sys_pre) - 8'h01)),
		.tick_o(sys_tick)
	);

	ccc_tick_div #(.W(8)) u_aux_pre (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(fast_int_tick_i),
		.ratio_m1_i(CCC_AUX_RATIO_M1),
		.tick_o(aux_tick)
	);

	// Master clock source mux
	always_comb begin
		if (aux_flag) begin
			next_master = aux_tick;
		end else begin
			unique case (cur_src)
				CCC_SRC_SLOW_INT: next_master = slow_int_tick_i;
				CCC_SRC_FAST_EXT: next_master = fast_ext_tick_i;
				default: next_master = sys_tick;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			master_tick_o <= 1'b0;
		end else begin
			master_tick_o <= next_master;
		end
	end

	// CPU and debug wire dividers
	ccc_tick_div #(.W(8)) u_cpu_div (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(master_tick_o),
		.ratio_m1_i(8'((9'h001 << cpu_div) - 9'h001)),
		.tick_o(cpu_tick_o)
	);

	ccc_tick_div #(.W(8)) u_dbg_div (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(master_tick_o),
		.ratio_m1_i({7'h00, dbg_div2}),
		.tick_o(debug_wire_tick_o)
	);

	// Trim: signed step added to factory calibration
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			fast_int_trim_o <= '0;
		end else begin
			fast_int_trim_o <= CAL_W'(factory_cal_i + {{(CAL_W-3){trim[2]}}, trim});
		end
	end

	// PLL: reference select and enable gate
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pll_tick_o <= 1'b0;
		end else begin
			pll_tick_o <= pll_en && (pll_src_ext ? fast_ext_tick_i : fast_int_tick_i);
		end
	end

	ccc_tick_div #(.W(8)) u_pll_div (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(pll_tick_o),
		.ratio_m1_i(8'(CCC_PLL_DIV_BASE + {6'h00, pll_div})),
		.tick_o(pll_div_tick_o)
	);

	ccc_tick_div #(.W(8)) u_pll_pre (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(pll_div_tick_o),
		.ratio_m1_i(8'((8'h01 << pll_pre) - 8'h01)),
		.tick_o(pll_pres_tick_o)
	);

	// Clock output: fifteen sources in select-code order, then n+1 divider
	assign out_srcs = {1'b0, pll_pres_tick_o, awu_tick_i, adc_tick_i, sm_tick_i,
		master_tick_o, cpu_tick_o, pll_tick_o, fast_ext_tick_i, slow_int_tick_i, fast_int_tick_i};
	assign out_tick_sel = out_en && out_srcs[out_sel];

	ccc_tick_div #(.W(8)) u_out_div (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(out_tick_sel),
		.ratio_m1_i(out_n),
		.tick_o(clock_output_tick_o)
	);

	// Output busy until the selected source ticks once after enable
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !out_en || (wr_div && avs_byteenable_i[1])) begin
			clock_output_busy_flag <= out_en && !sys_rst_i;
			clock_output_ready_flag <= 1'b0;
		end else if (out_tick_sel) begin
			clock_output_busy_flag <= 1'b0;
			clock_output_ready_flag <= 1'b1;
		end else begin
			clock_output_busy_flag <= !clock_output_ready_flag;
		end
	end

	// Checks on the logic above
	a_aux_failover: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		fail_event |=> aux_flag && clock_fail_detect_flag ##1 master_tick_o == $past(aux_tick))
		else $error("failure did not move master to aux");
	a_emerg_abort: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		emerg_clear |=> !switch_busy_flag && sw_state == CCC_SW_IDLE)
		else $error("emergency clear left busy set");
	a_clear_wins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(emerg_clear && wdat[CCC_CTRL_SW_EN] && !switch_busy_flag) |=> !switch_busy_flag [*2])
		else $error("switch started despite busy clear");
	a_irq_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		irq_o |-> $past(irq_mask & {switch_done_flag, clock_fail_detect_flag}) != 2'h0)
		else $error("interrupt without enabled pending bit");
	a_pend_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(wr_istat && wdat[CCC_IRQ_SWITCH] && !(sw_state == CCC_SW_WAIT && target_ready))
		|=> !switch_done_flag)
		else $error("switch pending bit not cleared");
	a_mon_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		monitor_en |=> monitor_en)
		else $error("failure monitor dropped");
	a_switch_done: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(sw_state == CCC_SW_WAIT && target_ready && !emerg_clear)
		|=> switch_done_flag && !switch_busy_flag && cur_src == $past(target_src))
		else $error("switch completion flags wrong");
	a_bus_answer: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus answer not one cycle later");
	a_pll_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!pll_en [*2] |-> !pll_tick_o)
		else $error("disabled pll produced a tick");
endmodule
`default_nettype wire

// ==== tb/ccc_clock_ctrl_tb.sv ====
// Self-checking bench of the clock controller: bus access, dividers, switch, failure and interrupts
`default_nettype none
module ccc_clock_ctrl_tb
	import ccc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CW = 8;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] avs_address_i = 8'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic fast_int_tick_i = 1'b0, slow_int_tick_i = 1'b0, fast_ext_tick_i = 1'b0;
	logic fast_int_ready_i = 1'b1, slow_int_ready_i = 1'b0, fast_ext_ready_i = 1'b1;
	logic fast_ext_fail_i = 1'b0;
	logic [5:0] sm_tick_i = 6'h00;
	logic adc_tick_i = 1'b0, awu_tick_i = 1'b0;
	logic [CW-1:0] factory_cal_i = 8'h80;
	logic [CW-1:0] fast_int_trim_o;
	logic master_tick_o, cpu_tick_o, debug_wire_tick_o, pll_tick_o, pll_div_tick_o, pll_pres_tick_o;
	logic clock_output_tick_o, irq_o;
	wire logic [6:0] tk;
	int err_total = 0;
	int cmp_count = 0;
	logic [1:0] cyc = 2'h0;
	logic [15:0] rnd = 16'h000F;
	logic c_mon = 1'b0, c_pen = 1'b0, c_psrc = 1'b0, c_dbg = 1'b1, c_oen = 1'b0;
	logic [7:0] q_a[$];
	logic [31:0] q_e[$];
	logic [31:0] q_m[$];
	logic [7:0] ra;
	logic [31:0] re, rm;
	int rate[15] = '{1, 2, 4, 1, 8, 8, 1, 1, 1, 1, 1, 1, 1, 1, 4};
	assign tk = {clock_output_tick_o, pll_pres_tick_o, pll_div_tick_o, pll_tick_o, debug_wire_tick_o, cpu_tick_o,
		master_tick_o};

	ccc_clock_ctrl #(.CAL_W(CW)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.fast_int_tick_i(fast_int_tick_i), .slow_int_tick_i(slow_int_tick_i), .fast_ext_tick_i(fast_ext_tick_i),
		.fast_int_ready_i(fast_int_ready_i), .slow_int_ready_i(slow_int_ready_i),
		.fast_ext_ready_i(fast_ext_ready_i), .fast_ext_fail_i(fast_ext_fail_i), .sm_tick_i(sm_tick_i),
		.adc_tick_i(adc_tick_i), .awu_tick_i(awu_tick_i), .factory_cal_i(factory_cal_i),
		.fast_int_trim_o(fast_int_trim_o), .master_tick_o(master_tick_o), .cpu_tick_o(cpu_tick_o),
		.debug_wire_tick_o(debug_wire_tick_o), .pll_tick_o(pll_tick_o), .pll_div_tick_o(pll_div_tick_o),
		.pll_pres_tick_o(pll_pres_tick_o), .clock_output_tick_o(clock_output_tick_o), .irq_o(irq_o));

	// Free running 100 MHz clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// Oscillator ticks: fast every cycle, slow every second, external every fourth
	always @(posedge clk_i) begin
		cyc <= cyc + 2'h1;
		fast_int_tick_i <= 1'b1;
		slow_int_tick_i <= cyc[0];
		fast_ext_tick_i <= (cyc == 2'h0);
		sm_tick_i <= 6'h3F;
		adc_tick_i <= 1'b1;
		awu_tick_i <= 1'b1;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [31:0] cw(input logic sw, input logic [1:0] tg, input logic em);
		cw = 32'h0;
		cw[CCC_CTRL_SW_EN] = sw;
		cw[CCC_CTRL_TARGET +: 2] = tg;
		cw[CCC_CTRL_MON_EN] = c_mon;
		cw[CCC_CTRL_PLL_EN] = c_pen;
		cw[CCC_CTRL_PLL_SRC] = c_psrc;
		cw[CCC_CTRL_DBG_DIV2] = c_dbg;
		cw[CCC_CTRL_EMERG] = em;
		cw[CCC_CTRL_OUT_EN] = c_oen;
	endfunction

	function automatic logic [31:0] dw(input logic [1:0] sp, input logic [2:0] cpu, input logic [2:0] tr,
		input logic [1:0] pd, input logic [1:0] pp, input logic [3:0] sel, input logic [7:0] n);
		dw = 32'h0;
		dw[CCC_DIV_SYS_PRE +: 2] = sp;
		dw[CCC_DIV_CPU +: 3] = cpu;
		dw[CCC_DIV_TRIM +: 3] = tr;
		dw[CCC_DIV_PLL +: 2] = pd;
		dw[CCC_DIV_PLL_PRE +: 2] = pp;
		dw[CCC_DIV_OUT_SEL +: 4] = sel;
		dw[CCC_DIV_OUT_N +: 8] = n;
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	// One bus access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_read_i <= !wr;
		avs_write_i <= wr;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	// Note the expected read value, then read
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		q_a.push_back(a);
		q_e.push_back(e);
		q_m.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic ctl(input logic sw, input logic [1:0] tg, input logic em);
		wr(CCC_OFF_CTRL, cw(sw, tg, em));
	endtask

	// Count ticks of one output over a window after settling
	task automatic meas(input int idx, input int win, input int e, input string nm);
		logic [31:0] c;
		c = 32'h0;
		repeat (260) @(posedge clk_i);
		repeat (win) begin
			@(posedge clk_i);
			c = c + {31'b0, tk[idx]};
		end
		chk(nm, e, c);
	endtask

	task automatic irq_is(input logic v);
		repeat (3) @(posedge clk_i);
		chk("irq_o", {31'b0, v}, {31'b0, irq_o});
	endtask

	task automatic complete_run();
		$display("TB: errors %0d, comparisons %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Read data checked against the oldest note at the answering edge
	always @(posedge clk_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'b0) begin
			if (q_e.size() == 0) begin
				chk("unexpected read", 32'h0, 32'h1);
			end else begin
				ra = q_a.pop_front();
				re = q_e.pop_front();
				rm = q_m.pop_front();
				chk($sformatf("reg %0h", ra), re, avs_readdata_o & rm);
			end
		end
	end

	// Watchdog
	initial begin
		repeat (50000) @(posedge clk_i);
		err_total++;
		complete_run();
	end

	// Main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(CCC_OFF_DIV, dw(CCC_RST_SYS_PRE, CCC_RST_CPU, CCC_RST_TRIM, CCC_RST_PLL, CCC_RST_PLL_PRE, CCC_RST_OUT_SEL,
			CCC_RST_OUT_N), 32'h00FFFFFF);
		rd(CCC_OFF_CTRL, cw(1'b0, 2'h0, 1'b0), 32'h000001FF);
		wr(8'h14, 32'hFFFFFFFF);
		rd(8'h14, 32'h0, 32'hFFFFFFFF);
		rd(CCC_OFF_STATUS, 32'h6, 32'h607);
		for (int s = 0; s < 4; s++) begin
			wr(CCC_OFF_DIV, dw(s, 0, 0, 0, 0, 0, 0));
			meas(0, 64, 64 >> s, "master_tick");
		end
		for (int k = 0; k < 8; k++) begin
			wr(CCC_OFF_DIV, dw(0, k, 0, 0, 0, 0, 0));
			meas(1, 256, 256 >> k, "cpu_tick");
		end
		meas(2, 64, 32, "debug_tick");
		c_dbg = 1'b0;
		ctl(1'b0, 2'h0, 1'b0);
		meas(2, 64, 64, "debug_tick");
		for (int k = 0; k < 8; k++) begin
			rnd = lfsr(rnd);
			factory_cal_i <= rnd[7:0];
			wr(CCC_OFF_DIV, dw(0, 0, k, 0, 0, 0, 0));
			repeat (3) @(posedge clk_i);
			chk("trim", {24'h0, rnd[7:0] + {{(CW - 3){k[2]}}, k[2:0]}}, {24'h0, fast_int_trim_o});
		end
		meas(3, 64, 0, "pll_tick");
		c_pen = 1'b1;
		ctl(1'b0, 2'h0, 1'b0);
		meas(3, 64, 64, "pll_tick");
		for (int d = 0; d < 4; d++) begin
			wr(CCC_OFF_DIV, dw(0, 0, 0, d, 0, 0, 0));
			meas(4, 420, 420 / (4 + d), "pll_div_tick");
		end
		for (int n = 0; n < 4; n++) begin
			wr(CCC_OFF_DIV, dw(0, 0, 0, 0, n, 0, 0));
			meas(5, 480, 480 >> (2 + n), "pll_pres_tick");
		end
		c_psrc = 1'b1;
		ctl(1'b0, 2'h0, 1'b0);
		meas(3, 64, 16, "pll_tick");
		c_psrc = 1'b0;
		// Switch to an unready slow oscillator, then abort it
		ctl(1'b1, 2'h1, 1'b0);
		rd(CCC_OFF_STATUS, 32'h10, 32'h610);
		ctl(1'b1, 2'h1, 1'b1);
		rd(CCC_OFF_STATUS, 32'h0, 32'h618);
		slow_int_ready_i <= 1'b1;
		ctl(1'b1, 2'h1, 1'b1);
		repeat (6) @(posedge clk_i);
		rd(CCC_OFF_STATUS, 32'h0, 32'h618);
		ctl(1'b1, 2'h1, 1'b0);
		repeat (6) @(posedge clk_i);
		rd(CCC_OFF_STATUS, 32'h208, 32'h618);
		meas(0, 64, 32, "master_tick");
		rd(CCC_OFF_IRQ_STAT, 32'h2, 32'h3);
		irq_is(1'b0);
		wr(CCC_OFF_IRQ_MASK, 32'h2);
		irq_is(1'b1);
		wr(CCC_OFF_IRQ_STAT, 32'h2);
		irq_is(1'b0);
		rd(CCC_OFF_IRQ_STAT, 32'h0, 32'h2);
		// External source, monitor on, then failure
		ctl(1'b1, 2'h2, 1'b0);
		repeat (6) @(posedge clk_i);
		wr(CCC_OFF_IRQ_MASK, 32'h1);
		c_mon = 1'b1;
		ctl(1'b0, 2'h2, 1'b0);
		meas(0, 64, 16, "master_tick");
		irq_is(1'b0);
		fast_ext_fail_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(CCC_OFF_STATUS, 32'h60, 32'h60);
		meas(0, 64, 8, "master_tick");
		irq_is(1'b1);
		fast_ext_fail_i <= 1'b0;
		wr(CCC_OFF_IRQ_STAT, 32'h1);
		irq_is(1'b0);
		// Clock output over every source, random divider
		c_oen = 1'b1;
		ctl(1'b0, 2'h2, 1'b0);
		for (int s = 0; s < 15; s++) begin
			rnd = lfsr(rnd);
			wr(CCC_OFF_DIV, dw(0, 0, 0, 0, 0, s, {6'h0, rnd[1:0]}));
			meas(6, 480, 480 / (rate[s] * (rnd[1:0] + 1)), $sformatf("out_tick sel %0d", s));
		end
		rd(CCC_OFF_STATUS, 32'h100, 32'h180);
		// Only byte lane 0 written; lane 1 fields keep their values
		avs_byteenable_i <= 4'h1;
		wr(CCC_OFF_DIV, 32'hFFFFFFFF);
		avs_byteenable_i <= 4'hF;
		rd(CCC_OFF_DIV, 32'h0000E0FF, 32'h0000FFFF);
		// Monitor enable cannot be withdrawn by software
		c_mon = 1'b0;
		ctl(1'b0, 2'h2, 1'b0);
		rd(CCC_OFF_CTRL, 32'h8, 32'h8);
		complete_run();
	end
endmodule
`default_nettype wire
